// [hw/pcs_pkg.sv]
// Purpose: Shared constants and types of the program counter and stack unit.
// Assumes: Register indices are word indices; the byte address is four times the index.
// Notes: Command and indirect access groups travel as packed structs.
`default_nettype none
package pcs_pkg;
  localparam int PC_W = 15;
  localparam int STK_DEPTH = 16;
  localparam int STK_AW = 4;
  localparam int SP_W = 5;
  localparam int ADR_W = 14;
  localparam int IDX_LSB = 2;
  localparam logic [4:0] SP_RESET = 5'h1f;
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic [14:0] INT_VECTOR = 15'h0004;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [11:0] REG_PC_LOW = 12'h002;
  localparam logic [11:0] REG_STATUS = 12'h003;
  localparam logic [11:0] REG_PTR0_LOW = 12'h004;
  localparam logic [11:0] REG_PTR0_HIGH = 12'h005;
  localparam logic [11:0] REG_PTR1_LOW = 12'h006;
  localparam logic [11:0] REG_PTR1_HIGH = 12'h007;
  localparam logic [11:0] REG_BANK = 12'h008;
  localparam logic [11:0] REG_ACCUM = 12'h009;
  localparam logic [11:0] REG_LATCH = 12'h00a;
  localparam logic [11:0] REG_PWR_CTRL = 12'h096;
  localparam logic [11:0] REG_CONFIG = 12'h097;
  localparam logic [11:0] REG_STATUS_FLAGS_SHADOW = 12'hfe4;
  localparam logic [11:0] REG_ACCUM_SHAD = 12'hfe5;
  localparam logic [11:0] REG_BANK_SHAD = 12'hfe6;
  localparam logic [11:0] REG_LATCH_SHAD = 12'hfe7;
  localparam logic [11:0] REG_PTR0_LOW_SHAD = 12'hfe8;
  localparam logic [11:0] REG_PTR0_HIGH_SHAD = 12'hfe9;
  localparam logic [11:0] REG_PTR1_LOW_SHAD = 12'hfea;
  localparam logic [11:0] REG_PTR1_HIGH_SHAD = 12'hfeb;
  localparam logic [11:0] REG_STACK_PTR = 12'hfed;
  localparam logic [11:0] REG_STACK_TOP_LOW = 12'hfee;
  localparam logic [11:0] REG_STACK_TOP_HIGH = 12'hfef;
  localparam int PWR_OVF_BIT = 7;
  localparam int PWR_UNF_BIT = 6;
  localparam int CFG_FAULT_RST_BIT = 0;
  localparam int PROG_BIT = 15;
  localparam logic [15:0] TRAD_LIMIT = 16'h1000;
  localparam logic [5:0] PORT_PAIR = 6'h00;
  typedef enum logic [3:0] {
    PCS_OP_NEXT, PCS_OP_PCL_WRITE, PCS_OP_CALL_LIT, PCS_OP_CALL_COMP, PCS_OP_BR_ACC,
    PCS_OP_BR_OP, PCS_OP_RETURN, PCS_OP_LITERAL_SUBROUTINE_EXIT, PCS_OP_INTERRUPT_EXIT, PCS_OP_INT_VECTOR
  } pcs_op_t;
  typedef enum logic [1:0] {PCS_ST_IDLE, PCS_ST_SETTLE, PCS_ST_FETCH} pcs_state_t;
  typedef struct packed {
    logic valid;
    pcs_op_t op;
    logic [10:0] operand;
    logic [7:0] data;
  } pcs_cmd_t;
  typedef struct packed {
    logic valid;
    logic sel;
    logic write;
    logic [7:0] wdata;
  } pcs_ind_req_t;
  typedef struct packed {
    logic valid;
    logic data_en;
    logic prog_en;
    logic write;
    logic zero;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pcs_ind_acc_t;
endpackage : pcs_pkg
`default_nettype wire

// [hw/pcs_stack_mem.sv]
// Purpose: Storage for the return stack entries.
// Assumes: One write port and one read port on the same clock.
// Notes: Read data is registered, so a changed address is seen one cycle later.
`default_nettype none
module pcs_stack_mem #(
  parameter int DEPTH = pcs_pkg::STK_DEPTH,
  parameter int WIDTH = pcs_pkg::PC_W,
  parameter int AW = pcs_pkg::STK_AW
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  import pcs_pkg::*;
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule : pcs_stack_mem
`default_nettype wire

// [hw/pcs_unit.sv]
// Purpose: Program counter sequencing, return stack and indirect pointer redirection.
// Assumes: The decoder holds a command until cmd_ready is seen high on the same edge.
// Notes: Registers are a classic Wishbone slave, one byte per aligned word.
// Operation
// - Program counter is 15 bits; low byte readable, high part from upper latch.
// - Every reset clears the whole program counter.
// - Writing the low byte loads bits 14:8 from the upper latch.
// - Literal call loads operand into bits 10:0, latch 6:3 into 14:11.
// - Computed call loads low byte from accumulator, high from upper latch.
// - Accumulator branch loads incremented counter plus unsigned accumulator.
// - Operand branch loads incremented counter plus signed operand.
// - Sixteen entry, 15-bit return stack outside program and data space.
// - Calls and interrupt vectoring push; returns and interrupt exit pop.
// - Pushes and returns leave the upper latch untouched; interrupt exit restores it from its shadow.
// - With fault reset off the stack wraps and overwrites the oldest entries.
// - Overflow and underflow always set their flags.
// - Five-bit stack pointer selects the entry seen through the top pair.
// - Push increments then writes; pop reads then decrements.
// - With fault reset on, overflow or underflow resets the device.
// - Indirect port accesses go to the location the pointer names.
// - A pointer naming a port reads zero and suppresses the write.
// - Each pointer is a 16-bit address from its high and low bytes.
// - Pointer addresses up to 0xfff map straight onto data registers.
// - Pointer bit 15 selects program memory: read only, low byte, extra cycle.
//
// Register access over Wishbone was chosen for this implementation.
`default_nettype none
module pcs_unit #(
  parameter logic FAULT_RST_DEFAULT = 1'b1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pcs_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire pcs_pkg::pcs_cmd_t cmd,
  output logic cmd_ready,
  input wire pcs_pkg::pcs_ind_req_t ind_req,
  output pcs_pkg::pcs_ind_acc_t ind_acc,
  output logic [pcs_pkg::PC_W-1:0] pc,
  output logic stack_fault_reset
);
  import pcs_pkg::*;

  logic [6:0] pc_upper_latch;
  logic [7:0] accum, status, bank_sel;
  logic [15:0] ptr0, ptr1;
  logic [7:0] status_flags_shadow, accum_shad, bank_shad, latch_shad;
  logic [15:0] ptr0_shad, ptr1_shad;
  logic [SP_W-1:0] stack_depth_pointer;
  logic stack_overflow_flag, stack_underflow_flag, stack_fault_reset_enable;
  pcs_state_t state, next_state;
  logic [PC_W-1:0] stk_rd, next_stk_wdata;
  logic next_stk_we;
  logic [STK_AW-1:0] next_stk_waddr;

  logic [11:0] idx;
  logic wb_req, wb_wr;
  logic cmd_go, push, pop, ovf_evt, unf_evt, fault;
  logic [SP_W-1:0] sp_inc, sp_dec;
  logic [PC_W-1:0] pc_inc;
  logic ind_go, ind_prog, ind_port;
  logic [15:0] ind_addr;

  assign idx = wb_adr_i[ADR_W-1:IDX_LSB];
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];
  assign cmd_go = cmd.valid & cmd_ready;
  assign push = cmd_go & (cmd.op inside {PCS_OP_CALL_LIT, PCS_OP_CALL_COMP,
                                         PCS_OP_INT_VECTOR});
  assign pop = cmd_go & (cmd.op inside {PCS_OP_RETURN, PCS_OP_LITERAL_SUBROUTINE_EXIT, PCS_OP_INTERRUPT_EXIT});
  assign sp_inc = stack_depth_pointer + 5'h01;
  assign sp_dec = stack_depth_pointer - 5'h01;
  // The fifth pointer bit tells a push past the last level from the empty state.
  assign ovf_evt = push & sp_inc[SP_W-1] & (stack_depth_pointer != SP_RESET);
  assign unf_evt = pop & (stack_depth_pointer == SP_RESET);
  assign fault = stack_fault_reset_enable & (ovf_evt | unf_evt);
  assign pc_inc = pc + 15'h0001;
  assign ind_go = ind_req.valid & cmd_ready;
  assign ind_addr = ind_req.sel ? ptr1 : ptr0;
  assign ind_prog = ind_addr[PROG_BIT];
  // Both ports sit at the foot of every bank below TRAD_LIMIT, so there only the low seven bits matter.
  assign ind_port = ~ind_prog & (ind_addr < TRAD_LIMIT) & (ind_addr[6:1] == PORT_PAIR);

  pcs_stack_mem #(
    .DEPTH(STK_DEPTH),
    .WIDTH(PC_W),
    .AW(STK_AW)
  ) u_stack (
    .clk(clk),
    .wr_en(next_stk_we),
    .wr_addr(next_stk_waddr),
    .wr_data(next_stk_wdata),
    .rd_addr(stack_depth_pointer[STK_AW-1:0]),
    .rd_data(stk_rd)
  );

  // A push writes the incremented slot; a faulting push writes nothing.
  always_comb begin
    next_stk_we = 1'b0;
    next_stk_waddr = stack_depth_pointer[STK_AW-1:0];
    next_stk_wdata = stk_rd;
    if (push && !fault) begin
      next_stk_we = 1'b1;
      next_stk_waddr = sp_inc[STK_AW-1:0];
      next_stk_wdata = (cmd.op == PCS_OP_INT_VECTOR) ? pc : pc_inc;
    end else if (wb_wr && !cmd_go && idx == REG_STACK_TOP_LOW) begin
      next_stk_we = 1'b1;
      next_stk_wdata = {stk_rd[PC_W-1:8], wb_dat_i[7:0]};
    end else if (wb_wr && !cmd_go && idx == REG_STACK_TOP_HIGH) begin
      next_stk_we = 1'b1;
      next_stk_wdata = {wb_dat_i[6:0], stk_rd[7:0]};
    end
  end

  // Registered stack read data lags any pointer or entry change by one cycle.
  always_comb begin
    next_state = PCS_ST_IDLE;
    if (state == PCS_ST_IDLE) begin
      if (cmd_go && (push || pop)) begin
        next_state = PCS_ST_SETTLE;
      end else if (ind_go && ind_prog) begin
        next_state = PCS_ST_FETCH;
      end else if (wb_wr && (idx inside {REG_STACK_PTR, REG_STACK_TOP_LOW,
                                         REG_STACK_TOP_HIGH})) begin
        next_state = PCS_ST_SETTLE;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= PCS_ST_IDLE;
      cmd_ready <= 1'b0;
    end else begin
      state <= next_state;
      cmd_ready <= (next_state == PCS_ST_IDLE);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc <= PC_RESET;
    end else if (fault) begin
      pc <= PC_RESET;
    end else if (cmd_go) begin
      unique case (cmd.op)
        PCS_OP_NEXT: pc <= pc_inc;
        PCS_OP_PCL_WRITE: pc <= {pc_upper_latch, cmd.data};
        PCS_OP_CALL_LIT: pc <= {pc_upper_latch[6:3], cmd.operand};
        PCS_OP_CALL_COMP: pc <= {pc_upper_latch, accum};
        PCS_OP_BR_ACC: pc <= pc_inc + {7'h00, accum};
        PCS_OP_BR_OP: pc <= pc_inc + {{6{cmd.operand[8]}}, cmd.operand[8:0]};
        PCS_OP_RETURN, PCS_OP_LITERAL_SUBROUTINE_EXIT, PCS_OP_INTERRUPT_EXIT: pc <= stk_rd;
        PCS_OP_INT_VECTOR: pc <= INT_VECTOR;
      endcase
    end else if (wb_wr && idx == REG_PC_LOW) begin
      pc <= {pc_upper_latch, wb_dat_i[7:0]};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stack_depth_pointer <= SP_RESET;
    end else if (fault) begin
      stack_depth_pointer <= SP_RESET;
    end else if (push) begin
      stack_depth_pointer <= sp_inc;
    end else if (pop) begin
      stack_depth_pointer <= sp_dec;
    end else if (wb_wr && idx == REG_STACK_PTR) begin
      stack_depth_pointer <= wb_dat_i[SP_W-1:0];
    end
  end

  // Flags survive the fault reset so software can see why it restarted; a new event wins
  // over a software clear in the same cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stack_overflow_flag <= 1'b0;
      stack_underflow_flag <= 1'b0;
      stack_fault_reset_enable <= FAULT_RST_DEFAULT;
      stack_fault_reset <= 1'b0;
    end else begin
      stack_fault_reset <= fault;
      if (ovf_evt) begin
        stack_overflow_flag <= 1'b1;
      end else if (wb_wr && idx == REG_PWR_CTRL) begin
        stack_overflow_flag <= wb_dat_i[PWR_OVF_BIT];
      end
      if (unf_evt) begin
        stack_underflow_flag <= 1'b1;
      end else if (wb_wr && idx == REG_PWR_CTRL) begin
        stack_underflow_flag <= wb_dat_i[PWR_UNF_BIT];
      end
      if (wb_wr && idx == REG_CONFIG) begin
        stack_fault_reset_enable <= wb_dat_i[CFG_FAULT_RST_BIT];
      end
    end
  end

  // Working registers: decoder events first, then software writes.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_upper_latch <= 7'h00;
      accum <= BYTE_ZERO;
      status <= STATUS_RESET;
      bank_sel <= BYTE_ZERO;
      ptr0 <= PTR_RESET;
      ptr1 <= PTR_RESET;
    end else if (fault) begin
      pc_upper_latch <= 7'h00;
    end else if (cmd_go && cmd.op == PCS_OP_INTERRUPT_EXIT) begin
      status <= {status[7:3], status_flags_shadow[2:0]};
      accum <= accum_shad;
      bank_sel <= bank_shad;
      pc_upper_latch <= latch_shad[6:0];
      ptr0 <= ptr0_shad;
      ptr1 <= ptr1_shad;
    end else if (cmd_go && cmd.op == PCS_OP_LITERAL_SUBROUTINE_EXIT) begin
      accum <= cmd.operand[7:0];
    end else if (wb_wr && !push) begin
      unique case (idx)
        REG_LATCH: pc_upper_latch <= wb_dat_i[6:0];
        REG_ACCUM: accum <= wb_dat_i[7:0];
        REG_STATUS: status <= wb_dat_i[7:0];
        REG_BANK: bank_sel <= {3'h0, wb_dat_i[4:0]};
        REG_PTR0_LOW: ptr0[7:0] <= wb_dat_i[7:0];
        REG_PTR0_HIGH: ptr0[15:8] <= wb_dat_i[7:0];
        REG_PTR1_LOW: ptr1[7:0] <= wb_dat_i[7:0];
        REG_PTR1_HIGH: ptr1[15:8] <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_flags_shadow <= BYTE_ZERO;
      accum_shad <= BYTE_ZERO;
      bank_shad <= BYTE_ZERO;
      latch_shad <= BYTE_ZERO;
      ptr0_shad <= PTR_RESET;
      ptr1_shad <= PTR_RESET;
    end else if (push && cmd.op == PCS_OP_INT_VECTOR) begin
      status_flags_shadow <= {5'h00, status[2:0]};
      accum_shad <= accum;
      bank_shad <= bank_sel;
      latch_shad <= {1'b0, pc_upper_latch};
      ptr0_shad <= ptr0;
      ptr1_shad <= ptr1;
    end else if (wb_wr) begin
      unique case (idx)
        REG_STATUS_FLAGS_SHADOW: status_flags_shadow <= {5'h00, wb_dat_i[2:0]};
        REG_ACCUM_SHAD: accum_shad <= wb_dat_i[7:0];
        REG_BANK_SHAD: bank_shad <= {3'h0, wb_dat_i[4:0]};
        REG_LATCH_SHAD: latch_shad <= {1'b0, wb_dat_i[6:0]};
        REG_PTR0_LOW_SHAD: ptr0_shad[7:0] <= wb_dat_i[7:0];
        REG_PTR0_HIGH_SHAD: ptr0_shad[15:8] <= wb_dat_i[7:0];
        REG_PTR1_LOW_SHAD: ptr1_shad[7:0] <= wb_dat_i[7:0];
        REG_PTR1_HIGH_SHAD: ptr1_shad[15:8] <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // Indirect redirection; the port itself holds no storage.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ind_acc <= '0;
    end else begin
      ind_acc.valid <= ind_go;
      ind_acc.data_en <= ind_go & ~ind_prog & ~ind_port;
      ind_acc.prog_en <= ind_go & ind_prog & ~ind_req.write;
      ind_acc.write <= ind_go & ind_req.write & ~ind_prog & ~ind_port;
      ind_acc.zero <= ind_go & ind_port & ~ind_req.write;
      ind_acc.addr <= ind_prog ? {1'b0, ind_addr[14:0]} : ind_addr;
      ind_acc.wdata <= ind_req.wdata;
    end
  end

  // Bus slave: one wait state, unmapped words read zero and ignore writes.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        unique case (idx)
          REG_PC_LOW: wb_dat_o[7:0] <= pc[7:0];
          REG_STATUS: wb_dat_o[7:0] <= status;
          REG_PTR0_LOW: wb_dat_o[7:0] <= ptr0[7:0];
          REG_PTR0_HIGH: wb_dat_o[7:0] <= ptr0[15:8];
          REG_PTR1_LOW: wb_dat_o[7:0] <= ptr1[7:0];
          REG_PTR1_HIGH: wb_dat_o[7:0] <= ptr1[15:8];
          REG_BANK: wb_dat_o[7:0] <= bank_sel;
          REG_ACCUM: wb_dat_o[7:0] <= accum;
          REG_LATCH: wb_dat_o[6:0] <= pc_upper_latch;
          REG_PWR_CTRL: begin
            wb_dat_o[PWR_OVF_BIT] <= stack_overflow_flag;
            wb_dat_o[PWR_UNF_BIT] <= stack_underflow_flag;
          end
          REG_CONFIG: wb_dat_o[CFG_FAULT_RST_BIT] <= stack_fault_reset_enable;
          REG_STATUS_FLAGS_SHADOW: wb_dat_o[7:0] <= status_flags_shadow;
          REG_ACCUM_SHAD: wb_dat_o[7:0] <= accum_shad;
          REG_BANK_SHAD: wb_dat_o[7:0] <= bank_shad;
          REG_LATCH_SHAD: wb_dat_o[7:0] <= latch_shad;
          REG_PTR0_LOW_SHAD: wb_dat_o[7:0] <= ptr0_shad[7:0];
          REG_PTR0_HIGH_SHAD: wb_dat_o[7:0] <= ptr0_shad[15:8];
          REG_PTR1_LOW_SHAD: wb_dat_o[7:0] <= ptr1_shad[7:0];
          REG_PTR1_HIGH_SHAD: wb_dat_o[7:0] <= ptr1_shad[15:8];
          REG_STACK_PTR: wb_dat_o[SP_W-1:0] <= stack_depth_pointer;
          REG_STACK_TOP_LOW: wb_dat_o[7:0] <= stk_rd[7:0];
          REG_STACK_TOP_HIGH: wb_dat_o[6:0] <= stk_rd[PC_W-1:8];
          default: ;
        endcase
      end
    end
  end

  property p_pcl_write;
    @(posedge clk) disable iff (!reset_n)
    cmd_go && cmd.op == PCS_OP_PCL_WRITE |=> pc == {$past(pc_upper_latch), $past(cmd.data)};
  endproperty
  a_pcl_write: assert property (p_pcl_write) else $error("low byte write lost latch");

  property p_call_lit;
    @(posedge clk) disable iff (!reset_n)
    push && !fault && cmd.op == PCS_OP_CALL_LIT
      |=> pc == {$past(pc_upper_latch[6:3]), $past(cmd.operand)};
  endproperty
  a_call_lit: assert property (p_call_lit) else $error("literal call target wrong");

  property p_call_comp;
    @(posedge clk) disable iff (!reset_n)
    push && !fault && cmd.op == PCS_OP_CALL_COMP
      |=> pc == {$past(pc_upper_latch), $past(accum)};
  endproperty
  a_call_comp: assert property (p_call_comp) else $error("computed call target wrong");

  property p_br_acc;
    @(posedge clk) disable iff (!reset_n)
    cmd_go && cmd.op == PCS_OP_BR_ACC
      |=> pc == 15'($past(pc) + 15'h0001 + 15'($past(accum)));
  endproperty
  a_br_acc: assert property (p_br_acc) else $error("accumulator branch wrong");

  property p_br_op;
    @(posedge clk) disable iff (!reset_n)
    cmd_go && cmd.op == PCS_OP_BR_OP && cmd.operand[8:0] == 9'h1ff |=> pc == $past(pc);
  endproperty
  a_br_op: assert property (p_br_op) else $error("branch of minus one must stay");

  property p_push_order;
    @(posedge clk) disable iff (!reset_n)
    push && !fault |=> stack_depth_pointer == 5'($past(stack_depth_pointer) + 5'h01)
      ##1 stk_rd == $past(pc, 2) || stk_rd == 15'($past(pc, 2) + 15'h0001);
  endproperty
  a_push_order: assert property (p_push_order) else $error("push order broken");

  property p_latch_kept;
    @(posedge clk) disable iff (!reset_n)
    (push || cmd.op == PCS_OP_RETURN && pop) && !fault |=> $stable(pc_upper_latch);
  endproperty
  a_latch_kept: assert property (p_latch_kept) else $error("stack op moved latch");

  property p_ovf_flag;
    @(posedge clk) disable iff (!reset_n)
    ovf_evt |=> stack_overflow_flag [*2];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not held");

  property p_fault_reset;
    @(posedge clk) disable iff (!reset_n)
    fault |=> stack_fault_reset && pc == PC_RESET && stack_depth_pointer == SP_RESET;
  endproperty
  a_fault_reset: assert property (p_fault_reset) else $error("fault reset missing");

  property p_port_zero;
    @(posedge clk) disable iff (!reset_n)
    ind_go && ind_port |=> !ind_acc.write && ind_acc.zero == !$past(ind_req.write);
  endproperty
  a_port_zero: assert property (p_port_zero) else $error("port self access leaked");

  property p_prog_wait;
    @(posedge clk) disable iff (!reset_n)
    ind_go && ind_prog |=> !cmd_ready && !ind_acc.write ##1 cmd_ready;
  endproperty
  a_prog_wait: assert property (p_prog_wait) else $error("flash read cycle wrong");

  c_overflow: cover property (@(posedge clk) disable iff (!reset_n) ovf_evt && !fault);
  c_fault: cover property (@(posedge clk) disable iff (!reset_n) fault);
  c_interrupt_exit: cover property (@(posedge clk) disable iff (!reset_n)
    cmd_go && cmd.op == PCS_OP_INTERRUPT_EXIT);
  c_prog_read: cover property (@(posedge clk) disable iff (!reset_n) ind_go && ind_prog);
endmodule : pcs_unit
`default_nettype wire

// [verif/pcs_decoder_model.sv]
// Purpose: Behavioural instruction decoder that issues commands and indirect requests.
// Assumes: A request is held until cmd_ready is sampled high at a rising edge.
// Notes: Released fields other than op are inverted, so a stale value is never read as a live one.
`default_nettype none
module pcs_decoder_model (
  input wire logic clk,
  input wire logic cmd_ready,
  input wire pcs_pkg::pcs_ind_acc_t ind_acc,
  output var pcs_pkg::pcs_cmd_t cmd,
  output var pcs_pkg::pcs_ind_req_t ind_req
);
  import pcs_pkg::*;
  initial begin
    cmd = '0;
    ind_req = '0;
  end
  task automatic issue(input pcs_op_t op, input logic [10:0] opd, input logic [7:0] d);
    @(posedge clk);
    cmd <= '{valid: 1'b1, op: op, operand: opd, data: d};
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd <= '{valid: 1'b0, op: op, operand: ~opd, data: ~d};
  endtask : issue
  task automatic ind(input logic s, input logic w, output pcs_ind_acc_t acc);
    @(posedge clk);
    ind_req <= '{valid: 1'b1, sel: s, write: w, wdata: 8'hc3};
    do @(posedge clk); while (cmd_ready !== 1'b1);
    ind_req <= '{valid: 1'b0, sel: ~s, write: ~w, wdata: 8'h3c};
    @(posedge clk);
    acc = ind_acc;
  endtask : ind
endmodule : pcs_decoder_model
`default_nettype wire

// [verif/tb.sv]
// Purpose: Self-checking bench for the program counter and stack unit.
// Assumes: Registers are reached one byte per word over classic Wishbone.
// Notes: Stack entries are only read after being written, as they are not reset.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pcs_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, cmd_ready, fault;
  logic [13:0] adr = 14'h0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0, dat_r;
  logic [14:0] pc;
  logic [7:0] rd;
  pcs_cmd_t cmd;
  pcs_ind_req_t ind_req;
  pcs_ind_acc_t acc, ind_acc;
  int errors = 0, n_checks = 0;
  always #10 clk = ~clk;
  pcs_unit #(.FAULT_RST_DEFAULT(1'b1)) pcs_unit_inst (.clk(clk), .reset_n(reset_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .cmd(cmd), .cmd_ready(cmd_ready),
    .ind_req(ind_req), .ind_acc(ind_acc), .pc(pc), .stack_fault_reset(fault));
  pcs_decoder_model pcs_decoder_model_inst (.clk(clk), .cmd_ready(cmd_ready),
    .ind_acc(ind_acc), .cmd(cmd), .ind_req(ind_req));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic [11:0] idx, input logic w, input logic [7:0] wd);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; sel <= 4'h1;
    adr <= {idx, 2'b00}; dat_w <= {24'h0, wd};
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_r[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb
  task automatic rdc(input logic [11:0] idx, input logic [7:0] exp);
    wb(idx, 1'b0, 8'h00);
    chk({8'h0, rd}, {8'h0, exp});
  endtask : rdc
  task automatic op(input pcs_op_t o, input logic [10:0] opd, input logic [7:0] d,
                    input logic [14:0] exp);
    pcs_decoder_model_inst.issue(o, opd, d);
    @(negedge clk);
    chk({1'b0, pc}, {1'b0, exp});
  endtask : op
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk({1'b0, pc}, 16'h0000);
    rdc(REG_STACK_PTR, 8'h1f);
    rdc(REG_ACCUM_SHAD, 8'h00);
    rdc(12'hfec, 8'h00);
    wb(REG_LATCH, 1'b1, 8'h15);
    wb(REG_ACCUM, 1'b1, 8'h77);
    op(PCS_OP_PCL_WRITE, 11'h0, 8'h34, 15'h1534);
    rdc(REG_PC_LOW, 8'h34);
    op(PCS_OP_NEXT, 11'h0, 8'h00, 15'h1535);
    $display("test sequencing done");
    op(PCS_OP_CALL_LIT, 11'h123, 8'h00, 15'h1123);
    rdc(REG_STACK_PTR, 8'h00);
    rdc(REG_STACK_TOP_LOW, 8'h36);
    rdc(REG_STACK_TOP_HIGH, 8'h15);
    rdc(REG_LATCH, 8'h15);
    op(PCS_OP_CALL_COMP, 11'h0, 8'h00, 15'h1577);
    op(PCS_OP_BR_ACC, 11'h0, 8'h00, 15'h15ef);
    op(PCS_OP_BR_OP, 11'h1fe, 8'h00, 15'h15ee);
    op(PCS_OP_RETURN, 11'h0, 8'h00, 15'h1124);
    op(PCS_OP_LITERAL_SUBROUTINE_EXIT, 11'h05a, 8'h00, 15'h1536);
    rdc(REG_ACCUM, 8'h5a);
    $display("test stack done");
    // Wrap mode first, so the underflow must only flag and not reset.
    wb(REG_CONFIG, 1'b1, 8'h00);
    pcs_decoder_model_inst.issue(PCS_OP_RETURN, 11'h0, 8'h00);
    rdc(REG_PWR_CTRL, 8'h40);
    wb(REG_PWR_CTRL, 1'b1, 8'h00);
    wb(REG_STACK_PTR, 1'b1, 8'h1f);
    for (int i = 0; i < 17; i++) begin
      op(PCS_OP_PCL_WRITE, 11'h0, 8'(i), {7'h15, 8'(i)});
      op(PCS_OP_INT_VECTOR, 11'h0, 8'h00, INT_VECTOR);
    end
    chk({15'h0, fault}, 16'h0000);
    rdc(REG_PWR_CTRL, 8'h80);
    rdc(REG_ACCUM_SHAD, 8'h5a);
    wb(REG_STACK_PTR, 1'b1, 8'h00);
    rdc(REG_STACK_TOP_LOW, 8'h10);
    wb(REG_STACK_PTR, 1'b1, 8'h01);
    rdc(REG_STACK_TOP_LOW, 8'h01);
    wb(REG_ACCUM, 1'b1, 8'h11);
    op(PCS_OP_INTERRUPT_EXIT, 11'h0, 8'h00, 15'h1501);
    rdc(REG_ACCUM, 8'h5a);
    wb(REG_CONFIG, 1'b1, 8'h01);
    wb(REG_STACK_PTR, 1'b1, 8'h1f);
    wb(REG_PWR_CTRL, 1'b1, 8'h00);
    op(PCS_OP_RETURN, 11'h0, 8'h00, 15'h0000);
    chk({15'h0, fault}, 16'h0001);
    rdc(REG_PWR_CTRL, 8'h40);
    rdc(REG_STACK_PTR, 8'h1f);
    $display("test fault done");
    // Columns: pointer select, high, low, write, expected address, {prog, write}; zero is expected only for k == 2.
    for (int k = 0; k < 4; k++) begin
      logic [35:0] t;
      t = k == 0 ? {1'b0, 8'h01, 8'h23, 1'b1, 16'h0123, 2'b01} :
          k == 1 ? {1'b1, 8'h00, 8'h81, 1'b1, 16'h0081, 2'b00} :
          k == 2 ? {1'b1, 8'h00, 8'h00, 1'b0, 16'h0000, 2'b00} :
                   {1'b0, 8'h80, 8'h10, 1'b0, 16'h0010, 2'b10};
      wb(REG_PTR0_HIGH + {t[35], 1'b0}, 1'b1, t[34:27]);
      wb(REG_PTR0_LOW + {t[35], 1'b0}, 1'b1, t[26:19]);
      pcs_decoder_model_inst.ind(t[35], t[18], acc);
      chk(acc.addr, t[17:2]);
      chk({13'h0, acc.prog_en, acc.write, acc.zero},
          {13'h0, t[1], t[0], k == 2});
      chk({14'h0, acc.valid, acc.data_en}, {14'h0, 1'b1, k == 0});
    end
    $display("test indirect done");
    conclude();
  end
endmodule : tb
`default_nettype wire
